// ===== hw/operand_map_pkg.sv
// Purpose: Shared constants for the operand address decoder and data-area map.
// Assumes: Word and bit addresses arrive as plain binary numbers.
// Notes:   All areas but the temporary bits live in one flat word store; the bases below lay them out.

package operand_map_pkg;

    // Area designators carried with each operand.
    localparam logic [2:0] AREA_RELAY = 3'h0;  // No designator: internal relay or special.
    localparam logic [2:0] AREA_AUX   = 3'h1;
    localparam logic [2:0] AREA_DM    = 3'h2;
    localparam logic [2:0] AREA_HOLD  = 3'h3;
    localparam logic [2:0] AREA_TC    = 3'h4;
    localparam logic [2:0] AREA_LINK  = 3'h5;
    localparam logic [2:0] AREA_TEMP  = 3'h6;

    // Word address limits, inclusive.
    localparam logic [10:0] IR_LAST      = 11'h0eb;  // 235
    localparam logic [10:0] SPECIAL_FIRST = 11'h0ec; // 236
    localparam logic [10:0] SPECIAL_LAST = 11'h0ff;  // 255
    localparam logic [10:0] AUX_LAST     = 11'h01b;  // 27
    localparam logic [10:0] DM_RW_LAST   = 11'h3e7;  // 999
    localparam logic [10:0] DM_RO_LAST   = 11'h7cf;  // 1999
    localparam logic [10:0] HOLD_LAST    = 11'h063;  // 99
    localparam logic [10:0] TC_LAST      = 11'h1ff;  // 511
    localparam logic [10:0] LINK_LAST    = 11'h03f;  // 63
    localparam logic [10:0] TEMP_LAST    = 11'h007;  // 7

    // Bit number limits: 00..15 in general, 00..07 in the last special word.
    localparam logic [6:0] BIT_LAST         = 7'h0f;
    localparam logic [6:0] SPECIAL_LAST_BIT = 7'h07;

    // Special words that user writes may change, one bit per word from word 236.
    localparam logic [19:0] SPECIAL_USER_WRITABLE = 20'h0000f;

    // Flat word store layout.
    localparam int          STORE_AW      = 12;
    localparam int          STORE_WORDS   = 4096;
    localparam logic [11:0] BASE_RELAY    = 12'h000;
    localparam logic [11:0] BASE_AUX      = 12'h100;
    localparam logic [11:0] BASE_HOLD     = 12'h11c;
    localparam logic [11:0] BASE_LINK     = 12'h180;
    localparam logic [11:0] BASE_TC_PV    = 12'h1c0;
    localparam logic [11:0] BASE_TC_FLAG  = 12'h3c0;
    localparam logic [11:0] BASE_DM       = 12'h3e0;

    // Work-bit clear sweep runs over relay words 0..IR_LAST.
    localparam logic [7:0] CLEAR_LAST = 8'heb;

    // Controller states, one-hot.
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ACCESS = 3'b010,
        ST_CLEAR  = 3'b100
    } state_t;

endpackage

// ===== hw/word_store.sv
// Purpose: Single-port word store holding every data area but the temporary bits.
// Assumes: One access per cycle; read data valid the cycle after the address.
// Notes:   No reset on the array, so retained areas keep their values.

`timescale 1ns/100ps
`default_nettype none

module word_store
    import operand_map_pkg::*;
(
    // Clock.
    input  wire logic                i_clk_sys,
    // Access port.
    input  wire logic                i_we,
    input  wire logic [STORE_AW-1:0] i_addr,
    input  wire logic [15:0]         i_wdata,
    output logic      [15:0]         o_rdata
);

    logic [15:0] mem [STORE_WORDS];

    // Contents survive reset, which is how the auxiliary and holding areas retain.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_we)
        begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end

endmodule // word_store

`default_nettype wire

// ===== hw/operand_resolve.sv
// Purpose: Range check and physical placement of one operand.
// Assumes: Inputs are stable for the cycle in which they are decoded.
// Notes:   Purely combinational; the caller registers what it needs.

`timescale 1ns/100ps
`default_nettype none

module operand_resolve
    import operand_map_pkg::*;
(
    // Operand.
    input  wire logic [2:0]          i_area,
    input  wire logic                i_is_bit,
    input  wire logic                i_write,
    input  wire logic                i_load_out,
    input  wire logic [10:0]         i_addr,
    input  wire logic [6:0]          i_bit_num,
    // Resolution.
    output logic                     o_ok,
    output logic                     o_temp,
    output logic [STORE_AW-1:0]      o_phys,
    output logic [3:0]               o_bitpos
);

    logic        bit_ok;
    logic [10:0] special_idx;

    always_comb
    begin
        bit_ok      = !i_is_bit || (i_bit_num <= BIT_LAST);
        special_idx = i_addr - SPECIAL_FIRST;
        o_ok        = 1'b0;
        o_temp      = 1'b0;
        o_phys      = BASE_RELAY;
        o_bitpos    = i_bit_num[3:0];
        unique case (i_area)
            AREA_RELAY:
            begin
                // Relay and special words share one numbering.
                o_ok   = bit_ok && (i_addr <= SPECIAL_LAST);
                o_phys = BASE_RELAY + STORE_AW'(i_addr);
                if ((i_addr == SPECIAL_LAST) && i_is_bit && (i_bit_num > SPECIAL_LAST_BIT))
                begin
                    o_ok = 1'b0;
                end
                // Flags belong to the controller; user writes only reach control words.
                if (i_write && (i_addr > IR_LAST) && (i_addr <= SPECIAL_LAST) &&
                    !SPECIAL_USER_WRITABLE[special_idx[4:0]])
                begin
                    o_ok = 1'b0;
                end
            end
            AREA_AUX:
            begin
                o_ok   = bit_ok && (i_addr <= AUX_LAST);
                o_phys = BASE_AUX + STORE_AW'(i_addr);
            end
            AREA_DM:
            begin
                // Word access only, and the upper half reads only.
                o_ok   = !i_is_bit &&
                         ((i_addr <= DM_RW_LAST) || (!i_write && i_addr <= DM_RO_LAST));
                o_phys = BASE_DM + STORE_AW'(i_addr);
            end
            AREA_HOLD:
            begin
                o_ok   = bit_ok && (i_addr <= HOLD_LAST);
                o_phys = BASE_HOLD + STORE_AW'(i_addr);
            end
            AREA_TC:
            begin
                // A bit operand names the completion flag, a word the present count.
                o_ok = i_addr <= TC_LAST;
                if (i_is_bit)
                begin
                    o_phys   = BASE_TC_FLAG + STORE_AW'(i_addr[8:4]);
                    o_bitpos = i_addr[3:0];
                end
                else
                begin
                    o_phys = BASE_TC_PV + STORE_AW'(i_addr[8:0]);
                end
            end
            AREA_LINK:
            begin
                o_ok   = bit_ok && (i_addr <= LINK_LAST);
                o_phys = BASE_LINK + STORE_AW'(i_addr);
            end
            AREA_TEMP:
            begin
                o_ok   = i_is_bit && i_load_out && (i_addr <= TEMP_LAST);
                o_temp = 1'b1;
            end
            default:
            begin
                o_ok = 1'b0;
            end
        endcase
    end

endmodule // operand_resolve

`default_nettype wire

// ===== hw/plc_operand_address_map.sv
// Purpose: Operand decoder and data-area map serving the instruction execution unit.
// Assumes: All inputs are produced on i_clk_sys; i_rst is the power-on reset.
// Notes:   Bit writes are read-modify-write, so a memory operand takes two cycles.
//
// Functional notes
// - Relay words 0-235, bits up to 23515.
// - Special words 236-255, bits up to 25507.
// - Auxiliary words 0-27, retained across power loss.
// - Data memory writable 0-999, read-only 1000-1999.
// - Holding words 0-99, retained across power loss.
// - Timer number: bit gives flag, word gives count.
// - Link words 0-63, all usable as work.
// - Temporary bits 0-7, load and output only.
// - No designator means relay or special by number.
// - Words are 16 bits, bit 0 rightmost.
// - Data memory is word-only; temporary bits bit-only; other areas word or bit.
// - Bit numbers valid only from 00 to 15.
// - Four 4-bit digits; decimal stored as BCD.
// - Flags set by controller; users cannot write them.
// - Unassigned relay words cleared on power loss or stop.

`timescale 1ns/100ps
`default_nettype none

module plc_operand_address_map
    import operand_map_pkg::*;
(
    // Clock and reset.
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // Operand request.
    input  wire logic        i_req,
    input  wire logic [2:0]  i_area,
    input  wire logic        i_is_bit,
    input  wire logic        i_write,
    input  wire logic        i_load_out,
    input  wire logic [10:0] i_addr,
    input  wire logic [6:0]  i_bit_num,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wbit,
    output logic             o_ready,
    // Operand answer.
    output logic             o_ack,
    output logic             o_invalid,
    output logic [15:0]      o_rdata,
    output logic             o_rbit,
    output logic             o_rdata_bcd,
    // Controller flag update.
    input  wire logic        i_flag_we,
    input  wire logic [4:0]  i_flag_word,
    input  wire logic [15:0] i_flag_data,
    output logic             o_flag_ready,
    // Work-bit clearing.
    input  wire logic        i_stop,
    input  wire logic        i_io_assigned,
    output logic [7:0]       o_io_query_word,
    output logic             o_clearing
);

    ////////////////////////////////////////////////////////////////////////////////
    // Operand decode and store.

    logic                res_ok;
    logic                res_temp;
    logic [STORE_AW-1:0] res_phys;
    logic [3:0]          res_bitpos;
    logic                mem_we;
    logic [STORE_AW-1:0] mem_addr;
    logic [15:0]         mem_wdata;
    logic [15:0]         mem_rdata;
    logic [15:0]         merged;

    operand_resolve u_resolve (
        .i_area     (i_area),
        .i_is_bit   (i_is_bit),
        .i_write    (i_write),
        .i_load_out (i_load_out),
        .i_addr     (i_addr),
        .i_bit_num  (i_bit_num),
        .o_ok       (res_ok),
        .o_temp     (res_temp),
        .o_phys     (res_phys),
        .o_bitpos   (res_bitpos)
    );

    word_store u_store (
        .i_clk_sys (i_clk_sys),
        .i_we      (mem_we),
        .i_addr    (mem_addr),
        .i_wdata   (mem_wdata),
        .o_rdata   (mem_rdata)
    );

    // A word is four digits; a decimal digit never exceeds nine.
    function automatic logic is_bcd(input logic [15:0] w);
        logic ok;
        ok = 1'b1;
        for (int d = 0; d < 4; d++)
        begin
            if (w[4*d +: 4] > 4'h9)
            begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Control state.

    state_t              state;
    state_t              next_state;
    logic [STORE_AW-1:0] op_phys;
    logic [STORE_AW-1:0] next_op_phys;
    logic [3:0]          op_bitpos;
    logic [3:0]          next_op_bitpos;
    logic                op_is_bit;
    logic                next_op_is_bit;
    logic                op_write;
    logic                next_op_write;
    logic [15:0]         op_wdata;
    logic [15:0]         next_op_wdata;
    logic                op_wbit;
    logic                next_op_wbit;
    logic                next_ack;
    logic                next_invalid;
    logic [15:0]         next_rdata;
    logic                next_rbit;
    logic [7:0]          temp_bits;
    logic [7:0]          next_temp_bits;
    logic [7:0]          clr_cnt;
    logic [7:0]          next_clr_cnt;
    logic                clr_pending;
    logic                next_clr_pending;
    logic                take;

    assign o_flag_ready    = (state == ST_IDLE) && !clr_pending && !i_stop;
    assign o_ready         = o_flag_ready && !i_flag_we;
    assign take            = i_req && o_ready;
    assign o_clearing      = state == ST_CLEAR;
    assign o_io_query_word = clr_cnt;

    // Bit 00 is the rightmost position of the word.
    always_comb
    begin
        merged            = mem_rdata;
        merged[op_bitpos] = op_wbit;
    end

    always_comb
    begin
        next_state       = state;
        next_op_phys     = op_phys;
        next_op_bitpos   = op_bitpos;
        next_op_is_bit   = op_is_bit;
        next_op_write    = op_write;
        next_op_wdata    = op_wdata;
        next_op_wbit     = op_wbit;
        next_ack         = 1'b0;
        next_invalid     = 1'b0;
        next_rdata       = o_rdata;
        next_rbit        = o_rbit;
        next_temp_bits   = temp_bits;
        next_clr_cnt     = clr_cnt;
        next_clr_pending = clr_pending || (i_stop && (state != ST_IDLE));
        mem_we           = 1'b0;
        mem_addr         = res_phys;
        mem_wdata        = i_wdata;
        unique case (state)
            ST_IDLE:
            begin
                if (clr_pending || i_stop)
                begin
                    next_state       = ST_CLEAR;
                    next_clr_cnt     = 8'h00;
                    next_clr_pending = 1'b0;
                end
                else if (i_flag_we)
                begin
                    // Controller-owned update of the special words.
                    mem_we    = 1'b1;
                    mem_addr  = BASE_RELAY + STORE_AW'(SPECIAL_FIRST) + STORE_AW'(i_flag_word);
                    mem_wdata = i_flag_data;
                end
                else if (take)
                begin
                    if (!res_ok)
                    begin
                        next_ack     = 1'b1;
                        next_invalid = 1'b1;
                    end
                    else if (res_temp)
                    begin
                        next_ack = 1'b1;
                        if (i_write)
                        begin
                            next_temp_bits[i_addr[2:0]] = i_wbit;
                        end
                        else
                        begin
                            next_rbit = temp_bits[i_addr[2:0]];
                        end
                    end
                    else
                    begin
                        next_state     = ST_ACCESS;
                        next_op_phys   = res_phys;
                        next_op_bitpos = res_bitpos;
                        next_op_is_bit = i_is_bit;
                        next_op_write  = i_write;
                        next_op_wdata  = i_wdata;
                        next_op_wbit   = i_wbit;
                    end
                end
            end
            ST_ACCESS:
            begin
                next_ack   = 1'b1;
                next_state = ST_IDLE;
                mem_addr   = op_phys;
                if (op_write)
                begin
                    mem_we    = 1'b1;
                    mem_wdata = op_is_bit ? merged : op_wdata;
                end
                else
                begin
                    next_rdata = mem_rdata;
                    next_rbit  = mem_rdata[op_bitpos];
                end
            end
            ST_CLEAR:
            begin
                // Words wired to I/O keep their state; every other relay word clears.
                mem_addr     = BASE_RELAY + STORE_AW'(clr_cnt);
                mem_wdata    = 16'h0000;
                mem_we       = !i_io_assigned;
                next_clr_cnt = clr_cnt + 8'h01;
                if (clr_cnt == CLEAR_LAST)
                begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // Power-up starts in the clear sweep, since power was just interrupted.
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            state       <= ST_CLEAR;
            op_phys     <= '0;
            op_bitpos   <= 4'h0;
            op_is_bit   <= 1'b0;
            op_write    <= 1'b0;
            op_wdata    <= 16'h0000;
            op_wbit     <= 1'b0;
            o_ack       <= 1'b0;
            o_invalid   <= 1'b0;
            o_rdata     <= 16'h0000;
            o_rbit      <= 1'b0;
            o_rdata_bcd <= 1'b1;
            temp_bits   <= 8'h00;
            clr_cnt     <= 8'h00;
            clr_pending <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            op_phys     <= next_op_phys;
            op_bitpos   <= next_op_bitpos;
            op_is_bit   <= next_op_is_bit;
            op_write    <= next_op_write;
            op_wdata    <= next_op_wdata;
            op_wbit     <= next_op_wbit;
            o_ack       <= next_ack;
            o_invalid   <= next_invalid;
            o_rdata     <= next_rdata;
            o_rbit      <= next_rbit;
            o_rdata_bcd <= is_bcd(next_rdata);
            temp_bits   <= next_temp_bits;
            clr_cnt     <= next_clr_cnt;
            clr_pending <= next_clr_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    logic [4:0] special_sel;
    assign special_sel = 5'(i_addr - SPECIAL_FIRST);

    sequence seq_take_mem;
        take && res_ok && !res_temp;
    endsequence

    sequence seq_mem_done;
        (state == ST_ACCESS) ##1 (o_ack && !o_invalid);
    endsequence

    AST_INVALID_NO_ACCESS: assert property (
        (take && !res_ok) |-> !mem_we ##1 (o_ack && o_invalid && state == ST_IDLE))
        else $error("Invalid operand reached the store or was not flagged.");

    AST_DM_BIT_REFUSED: assert property (
        (take && i_area == AREA_DM && i_is_bit) |=> o_invalid)
        else $error("Bit access to data memory was accepted.");

    AST_DM_RO_REFUSED: assert property (
        (take && i_area == AREA_DM && i_write && i_addr > DM_RW_LAST) |=> o_invalid)
        else $error("Write to read-only data memory was accepted.");

    AST_BIT_RANGE: assert property (
        (take && i_is_bit && i_area != AREA_TC && i_area != AREA_TEMP && i_bit_num > BIT_LAST)
        |=> o_invalid)
        else $error("Bit number above 15 was accepted.");

    AST_TEMP_LOADOUT: assert property (
        (take && i_area == AREA_TEMP && (!i_load_out || !i_is_bit)) |=> o_invalid)
        else $error("Temporary bit used outside load or output.");

    AST_RELAY_ACCEPT: assert property (
        (take && i_area == AREA_RELAY && !i_write && !i_is_bit && i_addr <= SPECIAL_LAST)
        |=> seq_mem_done)
        else $error("Relay or special word read was not served in two cycles.");

    AST_TC_DUAL: assert property (
        (take && i_area == AREA_TC && i_addr <= TC_LAST)
        |-> (mem_addr == (i_is_bit ? BASE_TC_FLAG + STORE_AW'(i_addr[8:4])
                                   : BASE_TC_PV + STORE_AW'(i_addr[8:0]))))
        else $error("Timer number resolved to the wrong store word.");

    AST_MEM_LATENCY: assert property (
        seq_take_mem |=> (state == ST_ACCESS) ##1 o_ack)
        else $error("Memory operand did not answer on the second edge.");

    AST_BIT_MERGE: assert property (
        (state == ST_ACCESS && op_write && op_is_bit)
        |-> (mem_wdata[op_bitpos] == op_wbit) &&
            ((mem_wdata & ~(16'h0001 << op_bitpos)) ===
             (mem_rdata & ~(16'h0001 << op_bitpos))))
        else $error("Bit write disturbed neighbouring bits.");

    AST_FLAG_USER_RO: assert property (
        (take && i_area == AREA_RELAY && i_write && i_addr > IR_LAST &&
         i_addr <= SPECIAL_LAST && !SPECIAL_USER_WRITABLE[special_sel])
        |=> o_invalid)
        else $error("User write to a flag word was accepted.");

    AST_CLEAR_SWEEP: assert property (
        (state == ST_CLEAR && mem_we)
        |-> (mem_addr <= STORE_AW'(IR_LAST)) && (mem_wdata == 16'h0000))
        else $error("Clear sweep wrote outside relay words.");

    AST_CLEAR_END: assert property (
        (state == ST_CLEAR && clr_cnt == CLEAR_LAST) |=> (state == ST_IDLE))
        else $error("Clear sweep did not end after the last relay word.");

endmodule // plc_operand_address_map

`default_nettype wire

// ===== tb/io_assign_model.sv
// Purpose: Execution-side answer to the clear sweep's I/O allocation query.
// Assumes: Relay words below IO_WORDS are allocated to I/O slots.
// Notes:   Answers in the same cycle, as the sweep samples it at once.

`timescale 1ns/100ps
`default_nettype none

module io_assign_model #(
    parameter int IO_WORDS = 10
) (
    input  wire logic [7:0] i_query_word,
    output logic            o_assigned
);
    // I/O words must survive a stop, so only work words are cleared.
    assign o_assigned = (int'(i_query_word) < IO_WORDS);
endmodule // io_assign_model

`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the operand decoder and data-area map.
// Assumes: The bench plays the execution unit; the model answers I/O queries.
// Notes:   The store is never reset, so every word read whose data is checked follows a write of its word.

`timescale 1ns/100ps
`default_nettype none

module testbench
    import operand_map_pkg::*;
;
    logic        clk, rst, req, is_bit, wr, lo, wbit, flag_we, stop, io_asg;
    logic        ready, ack, inval, rbit, bcd, flag_rdy, clearing;
    logic [2:0]  area;
    logic [4:0]  flag_word;
    logic [6:0]  bitn;
    logic [7:0]  qword;
    logic [10:0] addr;
    logic [15:0] wdata, flag_data, rdata;
    int          n_mismatch = 0;
    int          n_compared = 0;

    plc_operand_address_map u_plc_operand_address_map (
        .i_clk_sys(clk), .i_rst(rst), .i_req(req), .i_area(area), .i_is_bit(is_bit),
        .i_write(wr), .i_load_out(lo), .i_addr(addr), .i_bit_num(bitn), .i_wdata(wdata),
        .i_wbit(wbit), .o_ready(ready), .o_ack(ack), .o_invalid(inval), .o_rdata(rdata),
        .o_rbit(rbit), .o_rdata_bcd(bcd), .i_flag_we(flag_we), .i_flag_word(flag_word),
        .i_flag_data(flag_data), .o_flag_ready(flag_rdy), .i_stop(stop),
        .i_io_assigned(io_asg), .o_io_query_word(qword), .o_clearing(clearing));
    io_assign_model u_io_assign_model (.i_query_word(qword), .o_assigned(io_asg));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk16(nm, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Waiting on ready rather than a fixed count lets the bench count the sweep's clearing cycles and check them.
    task automatic sweep_check();
        int n;
        n = 0;
        for (int k = 0; k < 400 && ready !== 1'b1; k++)
        begin
            if (clearing === 1'b1)
                n++;
            @(posedge clk) #1;
        end
        chk16("sweep cycles", 16'h00ec, 16'(n));
        chk1("ready after sweep", 1'b1, ready);
    endtask
    task automatic do_reset();
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        sweep_check();
    endtask
    task automatic op(input logic [2:0] a, input logic b, input logic w, input logic l,
                      input logic [10:0] ad, input logic [6:0] bn, input logic [15:0] wd);
        {area, is_bit, wr, lo, addr, bitn, wdata, wbit} = {a, b, w, l, ad, bn, wd, wd[0]};
        req = 1'b1;
        for (int k = 0; k < 300 && ready !== 1'b1; k++)
            @(posedge clk) #1;
        @(posedge clk) #1;
        req = 1'b0;
        for (int k = 0; k < 4 && ack !== 1'b1; k++)
            @(posedge clk) #1;
        chk1("ack", 1'b1, ack);
    endtask
    task automatic put(input logic [2:0] a, input logic [10:0] ad, input logic [15:0] d);
        op(a, 1'b0, 1'b1, 1'b0, ad, 7'h00, d);
        chk1("write taken", 1'b0, inval);
    endtask
    task automatic get(input logic [2:0] a, input logic [10:0] ad, input logic [15:0] e);
        op(a, 1'b0, 1'b0, 1'b0, ad, 7'h00, 16'h0000);
        chk1("read taken", 1'b0, inval);
        chk16("read word", e, rdata);
    endtask
    task automatic bad(input logic [2:0] a, input logic b, input logic w, input logic [10:0] ad,
                       input logic [6:0] bn);
        op(a, b, w, 1'b0, ad, bn, 16'hffff);
        chk1("refused", 1'b1, inval);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_ranges();
        logic [2:0]  ga [6] = '{AREA_RELAY, AREA_RELAY, AREA_AUX, AREA_DM, AREA_HOLD, AREA_LINK};
        logic [10:0] gw [6] = '{11'h0eb, 11'h0ec, 11'h01b, 11'h3e7, 11'h063, 11'h03f};
        logic [2:0]  ba [6] = '{AREA_RELAY, AREA_AUX, AREA_DM, AREA_HOLD, AREA_LINK, AREA_TC};
        logic [10:0] bw [6] = '{11'h100, 11'h01c, 11'h7d0, 11'h064, 11'h040, 11'h200};
        for (int i = 0; i < 6; i++)
        begin
            put(ga[i], gw[i], 16'hc3a0 ^ 16'(i));
            get(ga[i], gw[i], 16'hc3a0 ^ 16'(i));
            bad(ba[i], 1'b0, 1'b0, bw[i], 7'h00);
        end
        bad(3'h7, 1'b0, 1'b0, 11'h000, 7'h00);
    endtask
    task automatic t_bits();
        put(AREA_RELAY, 11'h005, 16'h0000);
        op(AREA_RELAY, 1'b1, 1'b1, 1'b0, 11'h005, 7'h0f, 16'h0001);
        get(AREA_RELAY, 11'h005, 16'h8000);
        op(AREA_RELAY, 1'b1, 1'b0, 1'b0, 11'h005, 7'h0f, 16'h0000);
        chk1("bit 15", 1'b1, rbit);
        bad(AREA_RELAY, 1'b1, 1'b1, 11'h005, 7'h10);
        get(AREA_RELAY, 11'h005, 16'h8000);
        bad(AREA_RELAY, 1'b1, 1'b0, 11'h0ff, 7'h08);
        bad(AREA_DM, 1'b1, 1'b0, 11'h005, 7'h00);
        bad(AREA_DM, 1'b0, 1'b1, 11'h3e8, 7'h00);
        op(AREA_DM, 1'b0, 1'b0, 1'b0, 11'h7cf, 7'h00, 16'h0000);
        chk1("read-only read", 1'b0, inval);
        op(AREA_TC, 1'b1, 1'b1, 1'b0, 11'h011, 7'h00, 16'h0001);
        put(AREA_TC, 11'h011, 16'h1234);
        op(AREA_TC, 1'b1, 1'b0, 1'b0, 11'h011, 7'h00, 16'h0000);
        chk1("completion flag", 1'b1, rbit);
        get(AREA_TC, 11'h011, 16'h1234);
    endtask
    task automatic t_temp();
        op(AREA_TEMP, 1'b1, 1'b1, 1'b1, 11'h007, 7'h00, 16'h0001);
        chk1("temp write", 1'b0, inval);
        op(AREA_TEMP, 1'b1, 1'b0, 1'b1, 11'h007, 7'h00, 16'h0000);
        chk1("temp bit", 1'b1, rbit);
        op(AREA_TEMP, 1'b1, 1'b0, 1'b1, 11'h008, 7'h00, 16'h0000);
        chk1("temp range", 1'b1, inval);
        bad(AREA_TEMP, 1'b1, 1'b0, 11'h000, 7'h00);
        bad(AREA_TEMP, 1'b0, 1'b0, 11'h000, 7'h00);
    endtask
    task automatic t_bcd_flags();
        put(AREA_LINK, 11'h001, 16'h9099);
        get(AREA_LINK, 11'h001, 16'h9099);
        chk1("bcd", 1'b1, bcd);
        put(AREA_LINK, 11'h001, 16'h90a9);
        get(AREA_LINK, 11'h001, 16'h90a9);
        chk1("bcd", 1'b0, bcd);
        {flag_we, flag_word, flag_data} = {1'b1, 5'h04, 16'h5a5a};
        for (int k = 0; k < 300 && flag_rdy !== 1'b1; k++)
            @(posedge clk) #1;
        chk1("flag ready", 1'b1, flag_rdy);
        @(posedge clk) #1;
        flag_we = 1'b0;
        bad(AREA_RELAY, 1'b0, 1'b1, 11'h0f0, 7'h00);
        get(AREA_RELAY, 11'h0f0, 16'h5a5a);
    endtask
    task automatic t_clear();
        put(AREA_RELAY, 11'h003, 16'hffff);
        put(AREA_RELAY, 11'h032, 16'hffff);
        put(AREA_HOLD, 11'h00a, 16'h1357);
        put(AREA_AUX, 11'h014, 16'h2468);
        stop = 1'b1;
        @(posedge clk) #1;
        stop = 1'b0;
        sweep_check();
        get(AREA_RELAY, 11'h003, 16'hffff);
        get(AREA_RELAY, 11'h032, 16'h0000);
        put(AREA_RELAY, 11'h032, 16'hffff);
        do_reset();
        get(AREA_RELAY, 11'h032, 16'h0000);
        get(AREA_HOLD, 11'h00a, 16'h1357);
        get(AREA_AUX, 11'h014, 16'h2468);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        #(50 * 6000);
        n_mismatch++;
        give_verdict();
    end
    initial
    begin
        {req, is_bit, wr, lo, wbit, flag_we, stop, area, flag_word, bitn, addr} = '0;
        {wdata, flag_data} = '0;
        do_reset();
        t_ranges();
        t_bits();
        t_temp();
        t_bcd_flags();
        t_clear();
        give_verdict();
    end
endmodule // testbench

`default_nettype wire
